// File: hdl/modem_sdlc_regs.vh
// register map, field positions and timing constants of the modem/sdlc block
`ifndef MODEM_SDLC_REGS_VH
`define MODEM_SDLC_REGS_VH

// word offsets (word index in haddr[3:2])
`define OFS_RX_CTRL       2'h0
`define OFS_TX_DBUF       2'h1
`define OFS_TX_CTRL       2'h2
`define OFS_CONFIG        2'h3

// receive control fields
`define RX_READY_BIT      1
`define RX_RTS_BIT        2
`define RX_SECTX_BIT      3
`define RX_LINE_IE_BIT    5
`define RX_SECRCV_BIT     10
`define RX_RING_BIT       14
`define RX_CHANGE_BIT     15

// transmit control fields
`define TX_SEND_BIT       4
`define TX_IE_BIT         6
`define TX_DONE_BIT       7
`define TX_RESET_BIT      8
`define TX_ACTIVE_BIT     9

// transmit data buffer fields
`define DBUF_SOM_BIT      8

// config fields
`define CFG_KEEP_BIT      0
`define CFG_SECRCV_GND    1
`define CFG_SECTX_INH     2
`define CFG_MAINT_BIT     3

`define FLAG_PATTERN      8'h7E

// timing
`define CLK_MHZ           250
`define CLEAR_PULSE_NS    1000
`define RING_QUAL_MS      10
`define MAINT_CLK_KHZ     10
`define CLEAR_CYCLES      ((`CLEAR_PULSE_NS * `CLK_MHZ) / 1000)
`define RING_QUAL_CYCLES  (`RING_QUAL_MS * `CLK_MHZ * 1000)
`define MAINT_HALF_CYCLES ((`CLK_MHZ * 1000) / (2 * `MAINT_CLK_KHZ))

`endif

// File: hdl/line_sync.v
// two flip-flop synchroniser for one pin level
`timescale 1ns/100ps
module line_sync
(
    input  wire hclk,
    input  wire hresetn,
    input  wire pin,
    output reg  level
);
    reg first;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            first <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            first <= pin;
            level <= first;
        end
    end
endmodule

// File: hdl/modem_sdlc_ctrl.v
// modem control lines and sdlc transmit start-up behind an ahb-lite slave
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "modem_sdlc_regs.vh"

// Contract
// - ring line shows at receive bit 14; any transition sets change flag.
// - rising ring edge sets flag only after 10 ms; falling edge at once.
// - receive bits 1, 2, 3 drive ready, request-to-send, secondary transmit.
// - those three bits load on any word or low-byte write of receive reg.
// - clear resets modem bits unless keep option set; then software clears.
// - option forces secondary receive input to inactive zero.
// - option inhibits secondary transmit output regardless of its bit.
// - maintenance select gates internal 10 kHz clock onto timing output.
// - writing one to transmit bit 8 makes one clear pulse of 1 us.
// - clear resets active, send, irq enable, start bit; sets done.
// - while inactive, load qualifier clocks sync buffer each transmit edge.
// - skip-load qualifier is load AND not skip sequence.
// - inactive and not sending holds line at mark, data register clear.
// - end of any transmit buffer write clears done.
// - start bit synchronised on next edge; send-flag is start AND copy.
// - send, send-flag, load request flag and enable active as first step.
// - next transmit edge latches flag and active requests into synced copies.
// - flags repeat while start bit is set, then data characters; no 16-bit check is sent.
// - change flag bit 15 raises receive request if bit 5; read clears.
// - every flag sent is pattern 01111110.
module modem_sdlc_ctrl
#(
    parameter RING_QUAL_CYCLES  = `RING_QUAL_CYCLES,
    parameter MAINT_HALF_CYCLES = `MAINT_HALF_CYCLES
)
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        bus_init,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        ring_in,
    input  wire        secondary_receive_in,
    input  wire        transmit_clock_in,
    output reg         terminal_ready_out,
    output reg         request_to_send_out,
    output reg         secondary_transmit_out,
    output reg         maintenance_test_clock,
    output reg         modem_tx_data,
    output wire        rx_int_req
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire [2:0] pins = {transmit_clock_in, secondary_receive_in, ring_in};
    wire [2:0] pin_lvl;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : sync_gen
            line_sync u_sync
            (
                .hclk    (hclk),
                .hresetn (hresetn),
                .pin     (pins[g]),
                .level   (pin_lvl[g])
            );
        end
    endgenerate

    wire ring_lvl = pin_lvl[0];
    wire txclk_lvl = pin_lvl[2];

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    function lane_ok;
        input [2:0] size;
        input [1:0] ofs;
        input [1:0] lane;
        begin
            lane_ok = (size == 3'h2) || (size == 3'h1 && ofs[1] == lane[1])
                   || (size == 3'h0 && ofs == lane);
        end
    endfunction

    reg        dp_write;
    reg [1:0]  dp_reg;
    reg [1:0]  dp_ofs;
    reg [2:0]  dp_size;

    wire take = hsel && htrans[1] && hready;
    wire [1:0] a_reg = haddr[3:2];
    wire       a_map = (haddr[31:4] == 28'h0000000);
    wire       rd_rx = take && !hwrite && a_map && (a_reg == `OFS_RX_CTRL);

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_write <= 1'b0;
            dp_reg <= 2'h0;
            dp_ofs <= 2'h0;
            dp_size <= 3'h0;
        end
        else
        begin
            dp_write <= take && hwrite && a_map;
            dp_reg <= a_reg;
            dp_ofs <= haddr[1:0];
            dp_size <= hsize;
        end
    end

    wire wr_rx = dp_write && (dp_reg == `OFS_RX_CTRL);
    wire wr_db = dp_write && (dp_reg == `OFS_TX_DBUF);
    wire wr_tc = dp_write && (dp_reg == `OFS_TX_CTRL);
    wire wr_cf = dp_write && (dp_reg == `OFS_CONFIG);
    wire lo_ok = lane_ok(dp_size, dp_ofs, 2'h0);
    wire hi_ok = lane_ok(dp_size, dp_ofs, 2'h1);

    // ------------------------------------------------------------
    // registers and device clear
    // ------------------------------------------------------------
    reg [3:0] config_bits;
    reg [2:0] modem_bits;
    reg       line_ie;
    reg       change_flag;
    reg       send;
    reg       transmit_interrupt_enable;
    reg       transmit_done;
    reg       transmitter_active;
    reg       start_of_message_bit;
    reg [7:0] tx_byte;
    reg [7:0] clr_cnt;

    wire device_clear_pulse = (clr_cnt != 8'h00);
    wire clear_all = device_clear_pulse || bus_init;
    wire keep_modem = config_bits[`CFG_KEEP_BIT];
    wire secrcv_lvl = config_bits[`CFG_SECRCV_GND] ? 1'b0 : pin_lvl[1];

    localparam CLEAR_LEN = `CLEAR_CYCLES;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            clr_cnt <= 8'h00;
        else if (wr_tc && hi_ok && hwdata[`TX_RESET_BIT])
            clr_cnt <= CLEAR_LEN[7:0];
        else if (device_clear_pulse)
            clr_cnt <= clr_cnt - 8'h01;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            config_bits <= 4'h0;
            modem_bits <= 3'h0;
            line_ie <= 1'b0;
        end
        else
        begin
            if (wr_cf && lo_ok)
                config_bits <= hwdata[3:0];
            if (clear_all && !keep_modem)
                modem_bits <= 3'h0;
            else if (wr_rx && lo_ok)
                modem_bits <= hwdata[3:1];
            if (clear_all)
                line_ie <= 1'b0;
            else if (wr_rx && lo_ok)
                line_ie <= hwdata[`RX_LINE_IE_BIT];
        end
    end

    // modem-side outputs
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            terminal_ready_out <= 1'b0;
            request_to_send_out <= 1'b0;
            secondary_transmit_out <= 1'b0;
        end
        else
        begin
            terminal_ready_out <= modem_bits[0];
            request_to_send_out <= modem_bits[1];
            secondary_transmit_out <= modem_bits[2]
                && !config_bits[`CFG_SECTX_INH];
        end
    end

    // ------------------------------------------------------------
    // ring qualification and change flag
    // ------------------------------------------------------------
    reg        ring_d;
    reg [23:0] ring_cnt;

    wire ring_rise = ring_lvl && !ring_d;
    wire ring_fall = !ring_lvl && ring_d;
    wire ring_done = (ring_cnt == 24'h000001);
    wire set_change = ring_fall || ring_done;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ring_d <= 1'b0;
            ring_cnt <= 24'h000000;
            change_flag <= 1'b0;
        end
        else
        begin
            ring_d <= ring_lvl;
            if (ring_rise)
                ring_cnt <= RING_QUAL_CYCLES[23:0];
            else if (ring_cnt != 24'h000000)
                ring_cnt <= ring_cnt - 24'h000001;
            if (set_change)
                change_flag <= 1'b1;
            else if (rd_rx)
                change_flag <= 1'b0;
        end
    end

    assign rx_int_req = change_flag && line_ie;

    // ------------------------------------------------------------
    // transmit clock edge, qualifiers, bit sync buffer
    // ------------------------------------------------------------
    reg txclk_d;
    reg synced_start_of_message;
    reg synced_flag_request;
    reg synced_active_enable;

    wire delayed_transmit_clock = txclk_lvl && !txclk_d;
    wire skip_sequence = 1'b0;
    wire load = !transmitter_active;
    wire skip_load_qualifier = load && !skip_sequence;
    wire send_flag = start_of_message_bit && synced_start_of_message;
    wire flag_request = send && send_flag
        && (load || synced_active_enable);
    wire active_enable_request = send && (send_flag && load
        || synced_active_enable);
    wire en_done = send && synced_active_enable && synced_flag_request
        && send_flag && skip_load_qualifier;
    wire sync_clk = delayed_transmit_clock && load;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            txclk_d <= 1'b0;
            synced_start_of_message <= 1'b0;
            synced_flag_request <= 1'b0;
            synced_active_enable <= 1'b0;
        end
        else
        begin
            txclk_d <= txclk_lvl;
            if (clear_all)
            begin
                synced_start_of_message <= 1'b0;
                synced_flag_request <= 1'b0;
                synced_active_enable <= 1'b0;
            end
            else if (sync_clk)
            begin
                synced_start_of_message <= start_of_message_bit;
                synced_flag_request <= flag_request;
                synced_active_enable <= active_enable_request;
            end
        end
    end

    // ------------------------------------------------------------
    // transmit control and data buffer
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            send <= 1'b0;
            transmit_interrupt_enable <= 1'b0;
            transmit_done <= 1'b1;
            transmitter_active <= 1'b0;
            start_of_message_bit <= 1'b0;
            tx_byte <= 8'h00;
        end
        else if (clear_all)
        begin
            send <= 1'b0;
            transmit_interrupt_enable <= 1'b0;
            transmit_done <= 1'b1;
            transmitter_active <= 1'b0;
            start_of_message_bit <= 1'b0;
        end
        else
        begin
            if (wr_tc && lo_ok)
            begin
                send <= hwdata[`TX_SEND_BIT];
                transmit_interrupt_enable <= hwdata[`TX_IE_BIT];
            end
            if (delayed_transmit_clock && en_done)
                transmit_done <= 1'b1;
            else if (wr_db)
                transmit_done <= 1'b0;
            if (delayed_transmit_clock && synced_active_enable)
                transmitter_active <= 1'b1;
            if (wr_db && lo_ok)
                tx_byte <= hwdata[7:0];
            if (wr_db && hi_ok)
                start_of_message_bit <= hwdata[`DBUF_SOM_BIT];
        end
    end

    // ------------------------------------------------------------
    // serial data path: flag then data characters
    // ------------------------------------------------------------
    reg [2:0] bit_idx;
    reg       in_flag;
    reg [7:0] shifter;
    reg       transmit_data_out_reg;

    wire en_data = transmitter_active || send;
    wire [7:0] flag_bits = `FLAG_PATTERN;
    wire next_bit = in_flag ? flag_bits[bit_idx] : shifter[0];

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bit_idx <= 3'h0;
            in_flag <= 1'b1;
            shifter <= 8'h00;
            transmit_data_out_reg <= 1'b0;
            modem_tx_data <= 1'b1;
        end
        else
        begin
            modem_tx_data <= en_data ? transmit_data_out_reg : 1'b1;
            if (!en_data)
            begin
                transmit_data_out_reg <= 1'b0;
                bit_idx <= 3'h0;
                in_flag <= 1'b1;
            end
            else if (delayed_transmit_clock && synced_flag_request)
            begin
                transmit_data_out_reg <= next_bit;
                bit_idx <= bit_idx + 3'h1;
                if (!in_flag)
                    shifter <= {1'b0, shifter[7:1]};
                if (bit_idx == 3'h7)
                begin
                    in_flag <= start_of_message_bit;
                    shifter <= tx_byte;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // internal maintenance clock
    // ------------------------------------------------------------
    reg [13:0] maint_cnt;
    reg        maint_phase;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            maint_cnt <= 14'h0000;
            maint_phase <= 1'b0;
            maintenance_test_clock <= 1'b0;
        end
        else
        begin
            if (maint_cnt == MAINT_HALF_CYCLES[13:0] - 14'h0001)
            begin
                maint_cnt <= 14'h0000;
                maint_phase <= !maint_phase;
            end
            else
                maint_cnt <= maint_cnt + 14'h0001;
            maintenance_test_clock <= maint_phase
                && config_bits[`CFG_MAINT_BIT];
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    reg [31:0] next_rdata;

    always @*
    begin
        next_rdata = 32'h00000000;
        case (a_reg)
            `OFS_RX_CTRL:
            begin
                next_rdata[3:1] = modem_bits;
                next_rdata[`RX_LINE_IE_BIT] = line_ie;
                next_rdata[`RX_SECRCV_BIT] = secrcv_lvl;
                next_rdata[`RX_RING_BIT] = ring_lvl;
                next_rdata[`RX_CHANGE_BIT] = change_flag;
            end
            `OFS_TX_DBUF:
            begin
                next_rdata[7:0] = tx_byte;
                next_rdata[`DBUF_SOM_BIT] = start_of_message_bit;
            end
            `OFS_TX_CTRL:
            begin
                next_rdata[`TX_SEND_BIT] = send;
                next_rdata[`TX_IE_BIT] = transmit_interrupt_enable;
                next_rdata[`TX_DONE_BIT] = transmit_done;
                next_rdata[`TX_ACTIVE_BIT] = transmitter_active;
            end
            default:
                next_rdata[3:0] = config_bits;
        endcase
        if (!a_map)
            next_rdata = 32'h00000000;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (take && !hwrite)
            hrdata <= next_rdata;
    end
endmodule

// File: verification/modem_sdlc_chk_sva.sv
// port-level assertions for the modem control and sdlc start-up block
`timescale 1ns/100ps
module modem_sdlc_chk
#(
    parameter MAINT_HALF_CYCLES = 4
)
(
    input wire        hclk,
    input wire        hresetn,
    input wire        bus_init,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    input wire        ring_in,
    input wire        secondary_receive_in,
    input wire        transmit_clock_in,
    input wire        terminal_ready_out,
    input wire        request_to_send_out,
    input wire        secondary_transmit_out,
    input wire        maintenance_test_clock,
    input wire        modem_tx_data,
    input wire        rx_int_req
);
    // ----------------------------------------
    // shadow of write data phases and config
    // ----------------------------------------
    reg       ap_wr;
    reg       ap_ok;
    reg [1:0] ap_ofs;
    reg [1:0] ap_lo;
    reg [2:0] ap_sz;
    reg [3:0] cfg_sh;
    reg       sent_any;
    int       hi_run;
    int       lo_run;
    wire      low_ok = ap_wr && ap_ok && (ap_sz == 3'h2 || ap_lo == 2'h0);

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_wr    <= 1'h0;
            ap_ok    <= 1'h0;
            ap_ofs   <= 2'h0;
            ap_lo    <= 2'h0;
            ap_sz    <= 3'h0;
            cfg_sh   <= 4'h0;
            sent_any <= 1'h0;
            hi_run   <= 0;
            lo_run   <= 0;
        end
        else
        begin
            ap_wr    <= hsel && htrans[1] && hready && hwrite;
            ap_ok    <= haddr[31:4] == 28'h0;
            ap_ofs   <= haddr[3:2];
            ap_lo    <= haddr[1:0];
            ap_sz    <= hsize;
            if (low_ok && ap_ofs == 2'h3)
                cfg_sh <= hwdata[3:0];
            sent_any <= sent_any || (low_ok && ap_ofs == 2'h2 && hwdata[4]);
            hi_run   <= maintenance_test_clock ? hi_run + 1 : 0;
            lo_run   <= (cfg_sh[3] && !maintenance_test_clock) ? lo_run + 1 : 0;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    a_modem_load: assert property (low_ok && ap_ofs == 2'h0 |-> ##2
        terminal_ready_out == $past(hwdata[1], 2) && request_to_send_out == $past(hwdata[2], 2))
        else $error("modem outputs did not load");
    a_sectx_follow: assert property (low_ok && ap_ofs == 2'h0 && !cfg_sh[2] |-> ##2
        secondary_transmit_out == $past(hwdata[3], 2))
        else $error("secondary transmit did not load");
    a_sectx_inhibit: assert property (cfg_sh[2] && $past(cfg_sh[2]) |-> !secondary_transmit_out)
        else $error("secondary transmit not inhibited");
    a_clear_modem: assert property (bus_init && !cfg_sh[0] |-> ##2
        !terminal_ready_out && !request_to_send_out)
        else $error("modem outputs survived clear");
    a_keep_modem: assert property (bus_init && cfg_sh[0] && !low_ok |=>
        $stable(terminal_ready_out) && $stable(request_to_send_out))
        else $error("modem outputs changed with keep set");
    a_maint_off: assert property (!cfg_sh[3] && !$past(cfg_sh[3]) |-> !maintenance_test_clock)
        else $error("test clock runs unselected");
    a_maint_high: assert property (maintenance_test_clock |-> hi_run < MAINT_HALF_CYCLES)
        else $error("test clock high too long");
    a_maint_low: assert property (lo_run <= MAINT_HALF_CYCLES + 2)
        else $error("test clock low too long");
    a_line_idle: assert property (!sent_any |-> modem_tx_data)
        else $error("line left mark while idle");
endmodule

bind modem_sdlc_ctrl modem_sdlc_chk #(.MAINT_HALF_CYCLES(MAINT_HALF_CYCLES)) modem_sdlc_chk_inst
(
    .hclk, .hresetn, .bus_init, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .ring_in, .secondary_receive_in, .transmit_clock_in,
    .terminal_ready_out, .request_to_send_out, .secondary_transmit_out,
    .maintenance_test_clock, .modem_tx_data, .rx_int_req
);

// File: verification/modem_model.sv
// synchronous modem: transmit clock, ring and secondary lines, line monitor
`timescale 1ns/100ps
module modem_model
(
    input  wire clk_en,
    input  wire ring_cmd,
    input  wire sec_cmd,
    input  wire line_data,
    output reg  tx_clock,
    output wire ring_line,
    output wire sec_line,
    output reg  flag_seen
);
    reg [7:0] hist;

    assign ring_line = ring_cmd;
    assign sec_line  = sec_cmd;

    // stands low while disabled
    initial
    begin
        tx_clock  = 1'h0;
        flag_seen = 1'h0;
        hist      = 8'hFF;
        #3.3;
        forever
        begin
            #16;
            tx_clock = clk_en & ~tx_clock;
        end
    end

    // samples the line at each rising edge
    always @(posedge tx_clock)
    begin
        hist = {line_data, hist[7:1]};
        if (hist == 8'h7E)
            flag_seen = 1'h1;
    end
endmodule

// File: verification/tb.sv
// self-checking bench of the modem control and sdlc start-up block
`timescale 1ns/100ps
module tb;
    reg         hclk, hresetn, bus_init, hsel, hwrite, clk_en, ring_cmd, sec_cmd;
    reg  [1:0]  htrans;
    reg  [2:0]  hsize;
    reg  [31:0] haddr, hwdata, seed, r;
    wire        hreadyout, hresp, tr, rts, stx, mclk, txd, irq, tclk, ring, srx, flag_seen;
    wire [31:0] hrdata;
    wire [31:0] mdm = {29'h0, stx, rts, tr};
    integer     error_cnt, checks_done, i, n;

    modem_sdlc_ctrl #(.RING_QUAL_CYCLES(20), .MAINT_HALF_CYCLES(4)) modem_sdlc_ctrl_inst
    (
        .hclk(hclk), .hresetn(hresetn), .bus_init(bus_init), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ring_in(ring),
        .secondary_receive_in(srx), .transmit_clock_in(tclk), .terminal_ready_out(tr),
        .request_to_send_out(rts), .secondary_transmit_out(stx),
        .maintenance_test_clock(mclk), .modem_tx_data(txd), .rx_int_req(irq)
    );
    modem_model modem_model_inst
    (
        .clk_en(clk_en), .ring_cmd(ring_cmd), .sec_cmd(sec_cmd), .line_data(txd),
        .tx_clock(tclk), .ring_line(ring), .sec_line(srx), .flag_seen(flag_seen)
    );

    initial
    begin
        hclk = 1'h0;
        forever #2 hclk = ~hclk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction

    task xfer(input w, input [31:0] a, input [2:0] s, input [31:0] v);
        begin
            @(posedge hclk);
            hsel <= 1'h1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= s;
            @(posedge hclk);
            while (hreadyout !== 1'h1) @(posedge hclk);
            hsel <= 1'h0; htrans <= 2'h0; hwdata <= v;
            @(posedge hclk);
            while (hreadyout !== 1'h1) @(posedge hclk);
            r = hrdata;
        end
    endtask

    task rd(input [31:0] a);
        xfer(1'h0, a, 3'h2, 32'h0);
    endtask

    task wr(input [31:0] a, input [31:0] v);
        xfer(1'h1, a, 3'h2, v);
    endtask

    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e)
            begin
                error_cnt = error_cnt + 1;
                $display("mismatch %s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    task settle;
        repeat (3) @(negedge hclk);
    endtask

    task wirq(input v, input integer lim);
        for (i = 0; i < lim && irq !== v; i = i + 1) @(negedge hclk);
    endtask

    task pulse_init;
        begin
            @(posedge hclk) bus_init <= 1'h1;
            @(posedge hclk) bus_init <= 1'h0;
            settle;
        end
    endtask

    task conclude;
        begin
            $display("checks %0d mismatches %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    initial
    begin
        repeat (30000) @(posedge hclk);
        error_cnt = error_cnt + 1;
        conclude;
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        hresetn = 1'h0; bus_init = 1'h0; hsel = 1'h0; hwrite = 1'h0; htrans = 2'h0;
        hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0; clk_en = 1'h0; ring_cmd = 1'h0;
        sec_cmd = 1'h0; error_cnt = 0; checks_done = 0; seed = 32'h00016E3B;
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        chk("line", 32'h1, {31'h0, txd});
        rd(32'h8); chk("txctrl", 32'h80, r);
        rd(32'h0); chk("rxctrl", 32'h0, r);
        $display("test reset finished");
        for (n = 0; n < 8; n = n + 1)
        begin
            seed = xs(seed);
            wr(32'h0, seed); settle;
            chk("modem", {29'h0, seed[3:1]}, mdm);
            rd(32'h0); chk("rx back", seed & 32'h2E, r);
        end
        xfer(1'h1, 32'h1, 3'h0, ~seed); settle;
        chk("lane1", {29'h0, seed[3:1]}, mdm);
        xfer(1'h1, 32'h0, 3'h0, ~seed); settle;
        chk("lane0", {29'h0, ~seed[3:1]}, mdm);
        $display("test modem finished");
        sec_cmd <= 1'h1;
        wr(32'hC, 32'h4); wr(32'h0, 32'hE); settle;
        chk("inhibit", 32'h3, mdm);
        rd(32'h0); chk("srx on", 32'h40E, r);
        wr(32'hC, 32'h2); settle;
        chk("no inhibit", 32'h7, mdm);
        rd(32'h0); chk("srx gnd", 32'hE, r);
        wr(32'hC, 32'h1); pulse_init;
        chk("keep", 32'h7, mdm);
        wr(32'hC, 32'h0); pulse_init;
        chk("clear", 32'h0, mdm);
        sec_cmd <= 1'h0;
        $display("test config finished");
        wr(32'hC, 32'h8);
        for (i = 0; i < 40 && mclk !== 1'h1; i = i + 1) @(negedge hclk);
        for (n = 0; n < 40 && mclk === 1'h1; n = n + 1) @(negedge hclk);
        chk("maint high", 32'h4, n);
        wr(32'hC, 32'h0); settle;
        chk("maint off", 32'h0, {31'h0, mclk});
        $display("test maintenance finished");
        wr(32'h0, 32'h20);
        ring_cmd <= 1'h1;
        repeat (12) @(negedge hclk);
        chk("ring early", 32'h0, {31'h0, irq});
        wirq(1'h1, 40); chk("ring rise", 32'h1, {31'h0, irq});
        rd(32'h0); chk("ring rd", 32'hC020, r);
        @(negedge hclk); chk("irq clear", 32'h0, {31'h0, irq});
        ring_cmd <= 1'h0;
        wirq(1'h1, 8); chk("ring fall", 32'h1, {31'h0, irq});
        rd(32'h0); chk("fall rd", 32'h8020, r);
        $display("test ring finished");
        wr(32'h8, 32'h50); wr(32'h4, 32'h1A5);
        rd(32'h8); chk("done clr", 32'h50, r);
        rd(32'h4); chk("dbuf", 32'h1A5, r);
        wr(32'h8, 32'h100); repeat (260) @(posedge hclk);
        rd(32'h8); chk("dev clr", 32'h80, r);
        rd(32'h4); chk("som clr", 32'h0, r & 32'h100);
        rd(32'h0); chk("rx clr", 32'h0, r);
        $display("test clear finished");
        clk_en <= 1'h1;
        repeat (100) @(negedge hclk);
        chk("idle", 32'h3, {30'h0, txd, ~flag_seen});
        wr(32'h8, 32'h50); wr(32'h4, 32'h13C);
        for (i = 0; i < 2000 && flag_seen !== 1'h1; i = i + 1) @(negedge hclk);
        chk("flag", 32'h1, {31'h0, flag_seen});
        rd(32'h8); chk("active", 32'h200, r & 32'h200);
        wr(32'h8, 32'h100); repeat (270) @(negedge hclk);
        chk("idle again", 32'h1, {31'h0, txd});
        clk_en <= 1'h0;
        $display("test transmit finished");
        conclude;
    end
endmodule
